// ===== inc/axis_error_defines.vh
`ifndef AXIS_ERROR_DEFINES_VH
`define AXIS_ERROR_DEFINES_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL 8'h00
`define ADDR_SOFT_POS 8'h04
`define ADDR_SOFT_NEG 8'h08
`define ADDR_COMMAND 8'h0C
`define ADDR_MODE_WRITE 8'h10
`define ADDR_ERROR_STATUS 8'h14
`define ADDR_INT_STATUS 8'h18
`define ADDR_INT_MASK 8'h1C
`define ADDR_INTERP_MODE 8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTL_HW_POS_EN 0
`define CTL_HW_NEG_EN 1
`define CTL_SOFT_EN 2
`define CTL_SOFT_INSTANT 3
`define CTL_TRI_PREVENT 4
`define CTL_WIDTH 5
`define CTL_RESET 5'h13

// ----------------------------------------------------------------
// error status fields
// ----------------------------------------------------------------
`define ERR_SOFT_POS 0
`define ERR_SOFT_NEG 1
`define ERR_HW_POS 2
`define ERR_HW_NEG 3
`define ERR_ALARM 4
`define ERR_EMG 5
`define ERR_WIDTH 6

// ----------------------------------------------------------------
// commands and mode fields
// ----------------------------------------------------------------
`define CMD_ERROR_CLEAR 8'h79
`define CMD_INTERP_MODE 8'h2A
`define MODE_VEC_LSB 6
`define MODE_VEC_MSB 7
`define MODE_WIDTH 16
`define SOFT_RESET_POS 32'h7FFFFFFF
`define SOFT_RESET_NEG 32'h80000000

`endif

// ===== rtl/pin_sync.v
`timescale 1ns/1ns
// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module pin_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input wire sys_clk_i,
	input wire reset_i,
	input wire [WIDTH-1:0] pin_i,
	output reg [WIDTH-1:0] level_o
);

	reg [WIDTH-1:0] stage1_q;
	reg [WIDTH-1:0] stage2_q;
	reg [WIDTH-1:0] stage3_q;

	// stage1 is read by stage2 only; a level counts once 2 and 3 agree
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			stage1_q <= INIT;
			stage2_q <= INIT;
			stage3_q <= INIT;
			level_o <= INIT;
		end else begin
			stage1_q <= pin_i;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			// agreement takes stage2, a disagreement keeps the old level
			level_o <= (stage2_q & stage3_q) |
				(level_o & (stage2_q ^ stage3_q));
		end
	end

endmodule

// ===== rtl/axis_error_limit_status.v
`timescale 1ns/1ns
`include "axis_error_defines.vh"
// Operation
// - error flag set when a source activates during drive; stays set afterwards
// - error flag also set when a source is active at drive start
// - sources activating while stopped record no error
// - error status cleared by clear command 79h or next drive start
// - hardware limit inputs enabled separately; disabled ones never stop drive
// - soft limit values kept in their own dedicated registers
// - soft limit stop is decelerating or instant, chosen by configuration
// - triangle form prevention enabled after reset
// - command 2Ah applies mode bits D6,D7 as constant vector speed
module axis_error_limit_status (
	input wire sys_clk_i,
	input wire reset_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_write_i,
	input wire reg_read_i,
	output reg [31:0] reg_rdata_o,
	input wire drive_start_i,
	input wire drive_active_i,
	input wire drive_dir_pos_i,
	input wire [31:0] logical_position_i,
	input wire positive_hw_limit_input_n_i,
	input wire negative_hw_limit_input_n_i,
	input wire servo_alarm_n_i,
	input wire emergency_stop_n_i,
	output reg stop_decel_o,
	output reg stop_instant_o,
	output reg [`ERR_WIDTH-1:0] error_status_o,
	output reg triangle_prevent_o,
	output reg [1:0] vector_speed_mode_o,
	output wire irq_o
);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	reg [`CTL_WIDTH-1:0] control_q;
	reg [31:0] positive_soft_limit_value_q;
	reg [31:0] negative_soft_limit_value_q;
	reg [`MODE_WIDTH-1:0] mode_write_register_q;
	reg [`ERR_WIDTH-1:0] error_status_register_q;
	reg [`ERR_WIDTH-1:0] error_status_register_d;
	reg [`ERR_WIDTH-1:0] int_status_q;
	reg [`ERR_WIDTH-1:0] int_status_d;
	reg [`ERR_WIDTH-1:0] int_mask_q;
	reg [31:0] rdata_d;

	wire [3:0] pin_level;
	wire hw_pos_active;
	wire hw_neg_active;
	wire alarm_active;
	wire emg_active;
	wire soft_pos_hit;
	wire soft_neg_hit;
	wire [`ERR_WIDTH-1:0] source;
	wire [`ERR_WIDTH-1:0] newly_set;
	wire clear_cmd;
	wire mode_cmd;
	wire driving;

	// ----------------------------------------------------------------
	// address decode helper
	// ----------------------------------------------------------------
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// ----------------------------------------------------------------
	// pin inputs
	// ----------------------------------------------------------------
	// all four pins are active low and idle high
	pin_sync #(
		.WIDTH(4),
		.INIT(4'hF)
	) u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.pin_i({emergency_stop_n_i, servo_alarm_n_i,
			negative_hw_limit_input_n_i,
			positive_hw_limit_input_n_i}),
		.level_o(pin_level)
	);

	// disabled limit inputs are masked here so they can never stop a drive
	assign hw_pos_active = ~pin_level[0] & control_q[`CTL_HW_POS_EN];
	assign hw_neg_active = ~pin_level[1] & control_q[`CTL_HW_NEG_EN];
	assign alarm_active = ~pin_level[2];
	assign emg_active = ~pin_level[3];

	// ----------------------------------------------------------------
	// soft limit compare
	// ----------------------------------------------------------------
	// signed compare against the limit of the current direction only
	assign soft_pos_hit = control_q[`CTL_SOFT_EN] & drive_dir_pos_i &
		($signed(logical_position_i) >=
		$signed(positive_soft_limit_value_q));
	assign soft_neg_hit = control_q[`CTL_SOFT_EN] & ~drive_dir_pos_i &
		($signed(logical_position_i) <=
		$signed(negative_soft_limit_value_q));

	// source vector in error status layout
	assign source = {emg_active, alarm_active, hw_neg_active,
		hw_pos_active, soft_neg_hit, soft_pos_hit};

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	assign clear_cmd = reg_write_i & hit(reg_addr_i, `ADDR_COMMAND) &
		(reg_wdata_i[7:0] == `CMD_ERROR_CLEAR);
	assign mode_cmd = reg_write_i & hit(reg_addr_i, `ADDR_COMMAND) &
		(reg_wdata_i[7:0] == `CMD_INTERP_MODE);
	// the start cycle itself counts as driving
	assign driving = drive_active_i | drive_start_i;

	// ----------------------------------------------------------------
	// error latch
	// ----------------------------------------------------------------
	// clear first, then set: a source seen while driving in the clearing cycle wins
	always @* begin
		error_status_register_d = error_status_register_q;
		if (clear_cmd || drive_start_i) begin
			error_status_register_d = {`ERR_WIDTH{1'b0}};
		end
		if (driving) begin
			// active at start or during drive; held after source goes
			error_status_register_d = error_status_register_d | source;
		end
		// stopped axis: no set path at all
	end

	assign newly_set = error_status_register_d & ~error_status_register_q;

	// ----------------------------------------------------------------
	// interrupt status, write one to clear, set wins
	// ----------------------------------------------------------------
	always @* begin
		int_status_d = int_status_q;
		if (reg_write_i && hit(reg_addr_i, `ADDR_INT_STATUS)) begin
			int_status_d = int_status_q & ~reg_wdata_i[`ERR_WIDTH-1:0];
		end
		int_status_d = int_status_d | newly_set;
	end

	assign irq_o = |(int_status_q & int_mask_q);

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			error_status_register_q <= {`ERR_WIDTH{1'b0}};
			int_status_q <= {`ERR_WIDTH{1'b0}};
		end else begin
			error_status_register_q <= error_status_register_d;
			int_status_q <= int_status_d;
		end
	end

	// ----------------------------------------------------------------
	// software writable registers
	// ----------------------------------------------------------------
	// limits live apart from the compare registers, leaving those free
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			control_q <= `CTL_RESET;
			positive_soft_limit_value_q <= `SOFT_RESET_POS;
			negative_soft_limit_value_q <= `SOFT_RESET_NEG;
			mode_write_register_q <= {`MODE_WIDTH{1'b0}};
			int_mask_q <= {`ERR_WIDTH{1'b0}};
		end else if (reg_write_i) begin
			if (hit(reg_addr_i, `ADDR_CONTROL)) begin
				control_q <= reg_wdata_i[`CTL_WIDTH-1:0];
			end
			if (hit(reg_addr_i, `ADDR_SOFT_POS)) begin
				positive_soft_limit_value_q <= reg_wdata_i;
			end
			if (hit(reg_addr_i, `ADDR_SOFT_NEG)) begin
				negative_soft_limit_value_q <= reg_wdata_i;
			end
			if (hit(reg_addr_i, `ADDR_MODE_WRITE)) begin
				mode_write_register_q <= reg_wdata_i[`MODE_WIDTH-1:0];
			end
			if (hit(reg_addr_i, `ADDR_INT_MASK)) begin
				int_mask_q <= reg_wdata_i[`ERR_WIDTH-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// interpolation mode apply
	// ----------------------------------------------------------------
	// no speed range setting exists; the two mode bits are all it takes
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			vector_speed_mode_o <= 2'h0;
		end else if (mode_cmd) begin
			vector_speed_mode_o <=
				mode_write_register_q[`MODE_VEC_MSB:`MODE_VEC_LSB];
		end
	end

	// ----------------------------------------------------------------
	// stop requests and status outputs
	// ----------------------------------------------------------------
	// levels held while the cause stands during a drive
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			stop_decel_o <= 1'b0;
			stop_instant_o <= 1'b0;
			error_status_o <= {`ERR_WIDTH{1'b0}};
			triangle_prevent_o <= 1'b1;
		end else begin
			stop_decel_o <= driving & (soft_pos_hit | soft_neg_hit) &
				~control_q[`CTL_SOFT_INSTANT];
			stop_instant_o <= driving & ((((soft_pos_hit |
				soft_neg_hit) & control_q[`CTL_SOFT_INSTANT])) |
				hw_pos_active | hw_neg_active | alarm_active |
				emg_active);
			error_status_o <= error_status_register_d;
			triangle_prevent_o <= control_q[`CTL_TRI_PREVENT];
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		case (reg_addr_i)
			`ADDR_CONTROL: begin
				rdata_d[`CTL_WIDTH-1:0] = control_q;
			end
			`ADDR_SOFT_POS: begin
				rdata_d = positive_soft_limit_value_q;
			end
			`ADDR_SOFT_NEG: begin
				rdata_d = negative_soft_limit_value_q;
			end
			`ADDR_MODE_WRITE: begin
				rdata_d[`MODE_WIDTH-1:0] = mode_write_register_q;
			end
			`ADDR_ERROR_STATUS: begin
				rdata_d[`ERR_WIDTH-1:0] = error_status_register_q;
			end
			`ADDR_INT_STATUS: begin
				rdata_d[`ERR_WIDTH-1:0] = int_status_q;
			end
			`ADDR_INT_MASK: begin
				rdata_d[`ERR_WIDTH-1:0] = int_mask_q;
			end
			`ADDR_INTERP_MODE: begin
				rdata_d[1:0] = vector_speed_mode_o;
			end
			default: begin
				rdata_d = 32'h00000000;
			end
		endcase
	end

	// data valid only in the cycle after the read strobe, zero otherwise
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 32'h00000000;
		end else if (reg_read_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= 32'h00000000;
		end
	end

endmodule

// ===== sim/axis_error_checker_props.sv
`timescale 1ns/1ns
`include "axis_error_defines.vh"
// --------------
// port checker
// --------------
module axis_error_checker (
	input wire sys_clk_i,
	input wire reset_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_write_i,
	input wire reg_read_i,
	input wire [31:0] reg_rdata_o,
	input wire drive_start_i,
	input wire drive_active_i,
	input wire emergency_stop_n_i,
	input wire stop_decel_o,
	input wire stop_instant_o,
	input wire [`ERR_WIDTH-1:0] error_status_o,
	input wire triangle_prevent_o,
	input wire [1:0] vector_speed_mode_o,
	input wire irq_o
);
	// command decode; a start edge counts as driving
	wire cmd = reg_write_i && reg_addr_i == `ADDR_COMMAND;
	wire clr = cmd && reg_wdata_i[7:0] == `CMD_ERROR_CLEAR;
	wire mode_cmd = cmd && reg_wdata_i[7:0] == `CMD_INTERP_MODE;
	wire drv = drive_active_i || drive_start_i;
	wire hold = !clr && !drive_start_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	a_err_sticky: assert property ($past(hold) |->
		(error_status_o & $past(error_status_o)) == $past(error_status_o))
		else $error("error bit dropped");
	a_start_sets: assert property (
		!emergency_stop_n_i [*8] ##0 drive_start_i
		|=> error_status_o[`ERR_EMG])
		else $error("no error at start");
	a_idle_quiet: assert property (!drv |=>
		(error_status_o & ~$past(error_status_o)) == 0)
		else $error("error set while stopped");
	a_clear_cmd: assert property (clr && !drv |=> error_status_o == 0)
		else $error("clear left bits");
	a_stop_cause: assert property (stop_decel_o || stop_instant_o |->
		$past(drv) || $past(drv, 2))
		else $error("stop without drive");
	a_tri_reset: assert property ($fell(reset_i) |-> triangle_prevent_o
		&& !irq_o && !stop_instant_o && error_status_o == 0)
		else $error("bad state after reset");
	a_mode_cmd: assert property ($changed(vector_speed_mode_o) |->
		$past(mode_cmd))
		else $error("mode changed without command");
	a_rdata_slot: assert property (!$past(reg_read_i) |-> reg_rdata_o == 0)
		else $error("read data outside slot");
	// main scenarios reached
	cover property (clr);
	cover property (drive_start_i && !emergency_stop_n_i);
	cover property (irq_o);
endmodule
bind axis_error_limit_status axis_error_checker u_chk (.sys_clk_i, .reset_i,
	.reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
	.drive_start_i, .drive_active_i, .emergency_stop_n_i, .stop_decel_o,
	.stop_instant_o, .error_status_o, .triangle_prevent_o,
	.vector_speed_mode_o, .irq_o);

// ===== sim/host_model.sv
`timescale 1ns/1ns
`include "axis_error_defines.vh"
// --------------
// host processor
// --------------
module host_model (
	input wire sys_clk_i,
	input wire drive_active_i,
	output reg [7:0] addr_o = 8'h00,
	output reg [31:0] wdata_o = 32'h0,
	output reg write_o = 1'b0,
	output reg read_o = 1'b0
);
	// one-cycle write; stale data inverted so it never looks valid
	task wr(input [7:0] a, input [31:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		write_o <= 1'b1;
		@(posedge sys_clk_i);
		write_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// one-cycle read; the bench watches the answer
	task rd(input [7:0] a);
		@(posedge sys_clk_i);
		addr_o <= a;
		read_o <= 1'b1;
		@(posedge sys_clk_i);
		read_o <= 1'b0;
	endtask
	// clear once the axis has stopped, or after 1000 cycles if it never does
	task clear_errors;
		integer n;
		n = 0;
		while (drive_active_i && n < 1000) begin
			@(posedge sys_clk_i);
			n = n + 1;
		end
		wr(`ADDR_COMMAND, {24'h0, `CMD_ERROR_CLEAR});
	endtask
	// mode word rewritten before every mode command
	task set_vector(input [1:0] m, input [31:0] r);
		wr(`ADDR_MODE_WRITE, {16'h0, r[15:8], m, r[5:0]});
		wr(`ADDR_COMMAND, {24'h0, `CMD_INTERP_MODE});
	endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ns
`include "axis_error_defines.vh"
module tb;
	reg sys_clk = 1'b0;
	reg reset = 1'b1;
	reg start = 1'b0;
	reg act = 1'b0;
	reg dir = 1'b1;
	reg rd_seen = 1'b0;
	reg [3:0] pin_n = 4'hF;
	reg [31:0] pos = 32'h0;
	reg [31:0] seed = 32'h8F4FF25D;
	reg [31:0] v;
	reg [39:0] note;
	reg [39:0] exp_q[$];
	integer n_fail = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer k;
	wire [7:0] addr;
	wire [31:0] wdata, rdata;
	wire wr_s, rd_s, stop_d, stop_i, tri_o, irq;
	wire [1:0] vmode;
	wire [`ERR_WIDTH-1:0] err_o;
	// partner and block
	host_model host (.sys_clk_i(sys_clk), .drive_active_i(act),
		.addr_o(addr), .wdata_o(wdata), .write_o(wr_s), .read_o(rd_s));
	axis_error_limit_status dut (.sys_clk_i(sys_clk), .reset_i(reset),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s),
		.reg_read_i(rd_s), .reg_rdata_o(rdata), .drive_start_i(start),
		.drive_active_i(act), .drive_dir_pos_i(dir),
		.logical_position_i(pos), .positive_hw_limit_input_n_i(pin_n[0]),
		.negative_hw_limit_input_n_i(pin_n[1]), .servo_alarm_n_i(pin_n[2]),
		.emergency_stop_n_i(pin_n[3]), .stop_decel_o(stop_d),
		.stop_instant_o(stop_i), .error_status_o(err_o),
		.triangle_prevent_o(tri_o), .vector_speed_mode_o(vmode), .irq_o(irq));
	// 125 MHz clock
	always #4 sys_clk = ~sys_clk;
	// read answers come one cycle after the strobe; hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		rd_seen <= rd_s;
		if (rd_seen) begin
			note = exp_q.pop_front();
			chk($sformatf("reg %h", note[39:32]), note[31:0], rdata);
		end
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			give_verdict;
		end
	end
	function automatic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction
	// automatic: called from the read watcher and the main sequence
	task automatic chk(input string nm, input [31:0] e, input [31:0] g);
		n_checks = n_checks + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		exp_q.push_back({a, e});
		host.rd(a);
	endtask
	task wt(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	// pins pass a 3-stage synchroniser, so allow 8 cycles
	task src(input [3:0] p);
		@(posedge sys_clk);
		pin_n <= p;
		wt(8);
	endtask
	task drive(input a);
		@(posedge sys_clk);
		act <= a;
	endtask
	task pulse;
		@(posedge sys_clk);
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
	endtask
	task give_verdict;
		if (n_fail == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		rd(`ADDR_CONTROL, `CTL_RESET);
		rd(`ADDR_SOFT_POS, `SOFT_RESET_POS);
		rd(`ADDR_SOFT_NEG, `SOFT_RESET_NEG);
		rd(8'h40, 32'h0);
		chk("triangle", 1, 32'(tri_o));
		src(4'h7);
		src(4'hF);
		rd(`ADDR_ERROR_STATUS, 32'h0);
		drive(1'b1);
		src(4'hB);
		src(4'hF);
		rd(`ADDR_ERROR_STATUS, 32'h10);
		chk("error_status_o", 32'h10, {26'h0, err_o});
		rd(`ADDR_INT_STATUS, 32'h10);
		chk("irq", 0, 32'(irq));
		host.wr(`ADDR_INT_MASK, 32'h10);
		wt(2);
		chk("irq", 1, 32'(irq));
		host.wr(`ADDR_INT_STATUS, 32'h10);
		wt(2);
		chk("irq", 0, 32'(irq));
		drive(1'b0);
		host.clear_errors();
		rd(`ADDR_ERROR_STATUS, 32'h0);
		src(4'h7);
		pulse;
		rd(`ADDR_ERROR_STATUS, 32'h20);
		chk("error_status_o", 32'h20, {26'h0, err_o});
		src(4'hF);
		pulse;
		rd(`ADDR_ERROR_STATUS, 32'h0);
		// each limit pin first disabled, then enabled while held
		for (k = 0; k < 2; k = k + 1) begin
			host.wr(`ADDR_CONTROL, 32'h0);
			drive(1'b1);
			src(~(4'h1 << k));
			chk("stop_instant", 0, 32'(stop_i));
			rd(`ADDR_ERROR_STATUS, 32'h0);
			host.wr(`ADDR_CONTROL, 32'h1 << k);
			wt(3);
			chk("stop_instant", 1, 32'(stop_i));
			rd(`ADDR_ERROR_STATUS, 32'h4 << k);
			src(4'hF);
			drive(1'b0);
			host.clear_errors();
		end
		// soft limits: both directions, both stop kinds
		v = rnd() >> 2;
		v = v + 32'h1;
		host.wr(`ADDR_SOFT_POS, v);
		host.wr(`ADDR_SOFT_NEG, -v);
		for (k = 0; k < 4; k = k + 1) begin
			host.wr(`ADDR_CONTROL, {28'h0, k[1], 3'h4});
			@(posedge sys_clk);
			dir <= k[0];
			pos <= k[0] ? v - 32'h1 : 32'h1 - v;
			drive(1'b1);
			rd(`ADDR_ERROR_STATUS, 32'h0);
			@(posedge sys_clk);
			pos <= k[0] ? v : -v;
			wt(4);
			chk("stop_decel", !k[1], 32'(stop_d));
			chk("stop_instant", k[1], 32'(stop_i));
			rd(`ADDR_ERROR_STATUS, k[0] ? 32'h1 : 32'h2);
			drive(1'b0);
			host.clear_errors();
		end
		for (k = 0; k < 4; k = k + 1) begin
			host.set_vector(k[1:0], rnd());
			rd(`ADDR_INTERP_MODE, k);
			wt(1);
			chk("vector_mode", k, {30'h0, vmode});
		end
		wt(4);
		give_verdict;
	end
endmodule
